// File: ttc_modulator.sv
// ttc_modulator: stop/run clock gate pattern over an eight-cycle frame.
// assumes duty code d runs the clocks d+1 of every 8 cycles.
`timescale 1ns/1ps
module ttc_modulator
    import ttc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              en,
    input  wire logic [DUTY_W-1:0] duty,
    output logic                   run
);
    logic [DUTY_W-1:0] phase_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + DUTY_W'(1);
        end
    end

    // clocks run freely whenever modulation is off
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            run <= 1'b1;
        end else begin
            run <= !en || (phase_r <= duty);
        end
    end
endmodule : ttc_modulator

// File: ttc_pkg.sv
// ttc_pkg: constants and carrier types for the thermal throttle control block.
// assumes a single 10 MHz core clock and a synchronous active-low reset.
package ttc_pkg;

    localparam int NUM_CORES   = 2;
    localparam int NUM_THREADS = 4;
    localparam int NUM_RANKS   = 2;
    localparam int TEMP_W      = 8;
    localparam int DUTY_W      = 3;
    localparam int RATIO_W     = 6;
    localparam int VID_W       = 6;
    localparam int PERF_W      = 8;
    localparam int PERIOD_W    = 8;
    localparam int CNT_W       = 4;

    // fixed at manufacture; arbitrary plain value
    localparam logic [TEMP_W-1:0]  ACT_TEMP   = 8'h5F;
    localparam logic [DUTY_W-1:0]  AUTO_DUTY  = 3'h2;
    localparam logic [VID_W-1:0]   VID_STEP   = 6'h04;
    localparam logic [RATIO_W-1:0] RATIO_RST  = 6'h10;

    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_NS     = 1000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYC);

    localparam logic [1:0] IRQ_MSI = 2'h0;
    localparam logic [1:0] IRQ_SMI = 2'h1;
    localparam logic [1:0] IRQ_SCI = 2'h2;

    typedef enum logic [3:0] {
        RV_IDLE  = 4'b0001,
        RV_RATIO = 4'b0010,
        RV_VOLT  = 4'b0100,
        RV_RAISE = 4'b1000
    } ttc_rv_state_t;

    typedef struct packed {
        logic       clkMonEn;
        logic       rvMonEn;
        logic       hotBidir;
        logic       intOnAssert;
        logic       intOnDeassert;
        logic       sensThrottleEn;
        logic       sensIrqEn;
        logic [1:0] sensIrqKind;
        logic       alarmIrqEn;
        logic       alarmToSci;
    } ttc_cfg_t;

    typedef struct packed {
        logic [PERF_W-1:0] cur;
        logic [PERF_W-1:0] max;
        logic [PERF_W-1:0] min;
    } ttc_perf_t;

endpackage : ttc_pkg

// File: ttc_platform_model.sv
// ttc_platform_model: platform side of the hot and trip lines.
// assumes board pull-ups on both open-drain lines.
`timescale 1ns/1ps
module ttc_platform_model (
    input  wire logic extHot,
    input  wire logic procHotNOut,
    input  wire logic procHotNOe,
    input  wire logic thermalTripNOut,
    input  wire logic thermalTripNOe,
    output logic      hotPinN,
    output logic      tripPinN
);
    // wired-and: any party sinking wins, else the pull-up
    assign hotPinN  = !(extHot || (procHotNOe && !procHotNOut));
    assign tripPinN = !(thermalTripNOe && !thermalTripNOut);
endmodule : ttc_platform_model

// File: ttc_sync.sv
// ttc_sync: two-flop synchroniser for pin inputs.
// assumes the inputs change slowly against the core clock.
`timescale 1ns/1ps
module ttc_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : ttc_sync

// File: ttc_thermal_throttle_control.sv
// ttc_thermal_throttle_control: thermal protection control for a dual-core part.
// assumes pins arrive raw and the sensor, clock and power logic sit outside.
`timescale 1ns/1ps
module ttc_thermal_throttle_control
    import ttc_pkg::*;
(
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_n,
    input  wire ttc_pkg::ttc_cfg_t                       cfg,
    input  wire logic [ttc_pkg::NUM_CORES-1:0]           coreHot,
    input  wire logic                                    catTrip,
    input  wire logic [ttc_pkg::NUM_THREADS-1:0][7:0]    threadTemp,
    input  wire logic [ttc_pkg::NUM_THREADS-1:0][7:0]    threadThresh,
    input  wire logic [ttc_pkg::NUM_THREADS-1:0]         ondemandEn,
    input  wire logic [ttc_pkg::NUM_THREADS-1:0][2:0]    ondemandDuty,
    input  wire logic [1:0]                              tempSel,
    input  wire logic [ttc_pkg::RATIO_W-1:0]             busRatioStrap,
    input  wire logic [ttc_pkg::VID_W-1:0]               nominalVid,
    input  wire ttc_pkg::ttc_perf_t                      perfIn,
    input  wire logic [ttc_pkg::NUM_RANKS-1:0]           rankRdThrEn,
    input  wire logic [ttc_pkg::NUM_RANKS-1:0]           rankWrThrEn,
    input  wire logic [ttc_pkg::PERIOD_W-1:0]            fabricPeriod,
    input  wire logic                                    procHotNIn,
    input  wire logic                                    thermalAlarmNIn,
    output logic                                         procHotNOut,
    output logic                                         procHotNOe,
    output logic                                         thermalTripNOut,
    output logic                                         thermalTripNOe,
    output logic                                         haltExec,
    output logic                                         sleepS5Req,
    output logic [ttc_pkg::NUM_CORES-1:0]                coreClkRun,
    output logic [ttc_pkg::RATIO_W-1:0]                  coreRatio,
    output logic [ttc_pkg::VID_W-1:0]                    coreVid,
    output logic                                         hotAssertIrq,
    output logic                                         hotDeassertIrq,
    output logic                                         msiReq,
    output logic                                         smiReq,
    output logic                                         sciReq,
    output logic [ttc_pkg::TEMP_W-1:0]                   tempRdData,
    output logic [ttc_pkg::TEMP_W-1:0]                   actTempRd,
    output ttc_pkg::ttc_perf_t                           perfOut,
    output logic [ttc_pkg::NUM_RANKS-1:0]                rankRdThrottle,
    output logic [ttc_pkg::NUM_RANKS-1:0]                rankWrThrottle,
    output logic                                         fabricGrantEn,
    output logic                                         throttleActive
);
    import ttc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [1:0] pinSync;
    logic       procHotNSync;
    logic       alarmNSync;
    logic       alarmPrev_r;

    ttc_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     ({procHotNIn, thermalAlarmNIn}),
        .dout    (pinSync)
    );

    assign procHotNSync = pinSync[1];
    assign alarmNSync   = pinSync[0];

    ////////////////////////////////////////////////////////////////////////////
    // hot sources and throttle requests

    logic                   hotInt;
    logic                   extHot;
    logic                   sensOver;
    logic [NUM_THREADS-1:0] overNow;
    logic                   trigger;
    logic                   clkThrottle;
    logic                   rvThrottle;
    logic                   tripLatched_r;

    // either core hot counts for both cores
    assign hotInt = |coreHot;
    // pin is ignored unless configured bidirectional
    assign extHot = cfg.hotBidir && !procHotNSync;

    always_comb begin
        for (int t = 0; t < NUM_THREADS; t++) begin
            overNow[t] = threadTemp[t] >= threadThresh[t];
        end
    end

    assign sensOver    = cfg.sensThrottleEn && (|overNow);
    assign trigger     = hotInt || extHot || sensOver;
    // with neither monitor enabled an external hot has no effect
    assign clkThrottle = cfg.clkMonEn && trigger;
    assign rvThrottle  = cfg.rvMonEn && trigger;

    ////////////////////////////////////////////////////////////////////////////
    // processor-hot pin and its interrupts

    logic hotPrev_r;

    // only own heat drives the pin, so an external low cannot latch itself
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            procHotNOut <= 1'b1;
            procHotNOe  <= 1'b0;
        end else begin
            procHotNOut <= !hotInt;
            procHotNOe  <= hotInt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hotPrev_r      <= 1'b0;
            hotAssertIrq   <= 1'b0;
            hotDeassertIrq <= 1'b0;
        end else begin
            hotPrev_r      <= hotInt;
            hotAssertIrq   <= cfg.intOnAssert && hotInt && !hotPrev_r;
            hotDeassertIrq <= cfg.intOnDeassert && !hotInt && hotPrev_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock modulation: automatic and on-demand

    logic [DUTY_W-1:0] odDuty;
    logic [DUTY_W-1:0] modDuty;
    logic              modEn;
    logic              modRun;

    // highest performance means the longest run share
    always_comb begin
        odDuty = '0;
        for (int t = 0; t < NUM_THREADS; t++) begin
            if (ondemandEn[t] && ondemandDuty[t] > odDuty) begin
                odDuty = ondemandDuty[t];
            end
        end
    end

    assign modEn   = clkThrottle || (|ondemandEn);
    assign modDuty = clkThrottle ? AUTO_DUTY : odDuty;

    ttc_modulator u_mod (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .en      (modEn),
        .duty    (modDuty),
        .run     (modRun)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            coreClkRun <= '1;
        end else if (tripLatched_r || catTrip) begin
            coreClkRun <= '0;
        end else begin
            coreClkRun <= {NUM_CORES{modRun}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ratio and voltage stepping

    ttc_rv_state_t       rvState_r;
    logic [CNT_W-1:0]    rvCnt_r;
    logic [RATIO_W-1:0]  porRatio_r;
    logic                porCaught_r;

    // strap is caught once after reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            porCaught_r <= 1'b0;
            porRatio_r  <= RATIO_RST;
        end else if (!porCaught_r) begin
            porCaught_r <= 1'b1;
            porRatio_r  <= busRatioStrap;
        end
    end

    // voltage is raised before the ratio on the way back up,
    // so the core is never fast at the low voltage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rvState_r <= RV_IDLE;
            rvCnt_r   <= '0;
            coreRatio <= RATIO_RST;
            coreVid   <= '0;
        end else begin
            case (rvState_r)
                RV_IDLE: begin
                    coreVid <= nominalVid;
                    if (rvThrottle) begin
                        coreRatio <= porRatio_r >> 1;
                        rvCnt_r   <= SETTLE_CNT;
                        rvState_r <= RV_RATIO;
                    end else begin
                        coreRatio <= porRatio_r;
                    end
                end
                RV_RATIO: begin
                    if (!rvThrottle) begin
                        coreRatio <= porRatio_r;
                        rvState_r <= RV_IDLE;
                    end else if (rvCnt_r == '0) begin
                        coreVid   <= nominalVid - VID_STEP;
                        rvState_r <= RV_VOLT;
                    end else begin
                        rvCnt_r <= rvCnt_r - CNT_W'(1);
                    end
                end
                RV_VOLT: begin
                    if (!rvThrottle) begin
                        coreVid   <= nominalVid;
                        rvCnt_r   <= SETTLE_CNT;
                        rvState_r <= RV_RAISE;
                    end
                end
                RV_RAISE: begin
                    if (rvThrottle) begin
                        coreVid   <= nominalVid - VID_STEP;
                        rvState_r <= RV_VOLT;
                    end else if (rvCnt_r == '0) begin
                        coreRatio <= porRatio_r;
                        rvState_r <= RV_IDLE;
                    end else begin
                        rvCnt_r <= rvCnt_r - CNT_W'(1);
                    end
                end
                default: begin
                    rvState_r <= RV_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // catastrophic trip: latched until reset

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tripLatched_r   <= 1'b0;
            haltExec        <= 1'b0;
            sleepS5Req      <= 1'b0;
            thermalTripNOut <= 1'b1;
            thermalTripNOe  <= 1'b0;
        end else if (catTrip || tripLatched_r) begin
            tripLatched_r   <= 1'b1;
            haltExec        <= 1'b1;
            sleepS5Req      <= 1'b1;
            thermalTripNOut <= 1'b0;
            thermalTripNOe  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sensor and alarm interrupts

    logic [NUM_THREADS-1:0] overPrev_r;
    logic                   sensEvt;
    logic                   alarmEvt;

    assign sensEvt  = cfg.sensIrqEn && (|(overNow & ~overPrev_r));
    assign alarmEvt = cfg.alarmIrqEn && alarmPrev_r && !alarmNSync;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            overPrev_r  <= '0;
            alarmPrev_r <= 1'b1;
        end else begin
            overPrev_r  <= overNow;
            alarmPrev_r <= alarmNSync;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            msiReq <= 1'b0;
            smiReq <= 1'b0;
            sciReq <= 1'b0;
        end else begin
            msiReq <= sensEvt && cfg.sensIrqKind == IRQ_MSI;
            smiReq <= (sensEvt && cfg.sensIrqKind == IRQ_SMI)
                      || (alarmEvt && !cfg.alarmToSci);
            sciReq <= (sensEvt && cfg.sensIrqKind == IRQ_SCI)
                      || (alarmEvt && cfg.alarmToSci);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readback

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tempRdData <= '0;
            actTempRd  <= ACT_TEMP;
            perfOut    <= '0;
        end else begin
            tempRdData <= threadTemp[tempSel];
            actTempRd  <= ACT_TEMP;
            perfOut    <= perfIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DRAM and fabric throttling

    logic                thrAny;
    logic [PERIOD_W-1:0] fabCnt_r;

    assign thrAny = clkThrottle || rvThrottle;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rankRdThrottle <= '0;
            rankWrThrottle <= '0;
            throttleActive <= 1'b0;
        end else begin
            rankRdThrottle <= rankRdThrEn & {NUM_RANKS{thrAny}};
            rankWrThrottle <= rankWrThrEn & {NUM_RANKS{thrAny}};
            throttleActive <= thrAny;
        end
    end

    // one grant slot per period+1 cycles while throttling
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !thrAny) begin
            fabCnt_r <= '0;
        end else if (fabCnt_r >= fabricPeriod) begin
            fabCnt_r <= '0;
        end else begin
            fabCnt_r <= fabCnt_r + PERIOD_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fabricGrantEn <= 1'b1;
        end else begin
            fabricGrantEn <= !thrAny || fabCnt_r == '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_RATIO_FIRST: assert property (
        rvState_r == RV_IDLE && rvThrottle
        |=> coreRatio == (porRatio_r >> 1) && coreVid == nominalVid)
        else $error("ratio not halved before voltage step");

    AST_VOLT_AFTER: assert property (
        rvState_r == RV_RATIO && rvCnt_r == '0 && rvThrottle
        |=> rvState_r == RV_VOLT && coreVid == nominalVid - VID_STEP)
        else $error("voltage not stepped down after settle");

    AST_ACT_TEMP: assert property (
        ##1 actTempRd == ACT_TEMP)
        else $error("activation temperature readback wrong");

    AST_HOT_PIN: assert property (
        hotInt |=> procHotNOe && !procHotNOut)
        else $error("hot pin not driven low");

    AST_HOT_IRQ: assert property (
        $rose(hotInt) && cfg.intOnAssert |=> hotAssertIrq ##1 !hotAssertIrq)
        else $error("hot assertion interrupt missing");

    AST_OUT_ONLY: assert property (
        !cfg.hotBidir && !hotInt && !sensOver |-> !clkThrottle && !rvThrottle)
        else $error("pin input acted in output-only mode");

    AST_EXT_AUTO: assert property (
        cfg.hotBidir && !procHotNSync && cfg.clkMonEn |-> modEn && modDuty == AUTO_DUTY)
        else $error("external hot did not start modulation");

    AST_BOTH_CORES: assert property (
        coreClkRun[0] == coreClkRun[1])
        else $error("cores throttled differently");

    AST_TRIP: assert property (
        catTrip |=> haltExec && !thermalTripNOut && thermalTripNOe && coreClkRun == '0)
        else $error("trip did not halt and drive pin");

    AST_S5_HOLD: assert property (
        sleepS5Req |=> sleepS5Req [*3])
        else $error("soft-off request dropped");

    AST_ALARM_SCI: assert property (
        $fell(alarmNSync) && cfg.alarmIrqEn && cfg.alarmToSci |=> sciReq)
        else $error("alarm did not raise system-control interrupt");

    AST_FAB_GAP: assert property (
        thrAny && fabricPeriod == 8'h03 && !fabricGrantEn ##1 fabricGrantEn && thrAny
        |=> !fabricGrantEn)
        else $error("fabric grant not spaced");

endmodule : ttc_thermal_throttle_control

// File: ttc_thermal_throttle_control_test.sv
// ttc_thermal_throttle_control_test: directed checks of the throttle block.
// assumes outputs settle within 10 ns of the clock edge.
`timescale 1ns/1ps
module ttc_thermal_throttle_control_test;
    import ttc_pkg::*;
    logic ref_clk, rst_n, catTrip, thermalAlarmNIn, extHot, hotPinN, tripPinN;
    logic procHotNOut, procHotNOe, thermalTripNOut, thermalTripNOe, haltExec, sleepS5Req;
    logic hotAssertIrq, hotDeassertIrq, msiReq, smiReq, sciReq, fabricGrantEn, throttleActive;
    ttc_cfg_t                    cfg;
    ttc_perf_t                   perfIn, perfOut;
    logic [NUM_CORES-1:0]        coreHot, coreClkRun;
    logic [NUM_THREADS-1:0][7:0] threadTemp, threadThresh;
    logic [NUM_THREADS-1:0]      ondemandEn;
    logic [NUM_THREADS-1:0][2:0] ondemandDuty;
    logic [1:0]                  tempSel;
    logic [RATIO_W-1:0]          coreRatio;
    logic [VID_W-1:0]            coreVid;
    logic [NUM_RANKS-1:0]        rankRdThrEn, rankWrThrEn, rankRdThrottle, rankWrThrottle;
    logic [PERIOD_W-1:0]         fabricPeriod;
    logic [TEMP_W-1:0]           tempRdData, actTempRd;
    int                          badCount, checked, n0, n1, n2;

    ////////////////////////////////////////////////////////////////////////
    ttc_thermal_throttle_control i_dut (.ref_clk, .rst_n, .cfg, .coreHot, .catTrip,
        .threadTemp, .threadThresh, .ondemandEn, .ondemandDuty, .tempSel,
        .busRatioStrap(6'h14), .nominalVid(6'h20), .perfIn, .rankRdThrEn, .rankWrThrEn,
        .fabricPeriod, .procHotNIn(hotPinN), .thermalAlarmNIn, .procHotNOut, .procHotNOe,
        .thermalTripNOut, .thermalTripNOe, .haltExec, .sleepS5Req, .coreClkRun, .coreRatio,
        .coreVid, .hotAssertIrq, .hotDeassertIrq, .msiReq, .smiReq, .sciReq, .tempRdData,
        .actTempRd, .perfOut, .rankRdThrottle, .rankWrThrottle, .fabricGrantEn,
        .throttleActive);
    ttc_platform_model i_plat (.extHot, .procHotNOut, .procHotNOe, .thermalTripNOut,
        .thermalTripNOe, .hotPinN, .tripPinN);

    ////////////////////////////////////////////////////////////////////////
    task tick(int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask : tick
    task chk(logic [31:0] got, logic [31:0] exp, string m);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    // counts run cycles and grants over one 8-cycle frame
    task runs;
        n0 = 0; n1 = 0; n2 = 0;
        repeat (8) begin
            tick(1);
            n0 += coreClkRun[0]; n1 += coreClkRun[1]; n2 += fabricGrantEn;
        end
    endtask : runs
    task summarize;
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #(1000 * CLK_PERIOD_NS);
        badCount++;
        summarize;
    end
    initial begin
        rst_n = 0; catTrip = 0; thermalAlarmNIn = 1; extHot = 0; cfg = '0; coreHot = 0;
        threadTemp = '0; threadThresh = '1; ondemandEn = 0; ondemandDuty = '0; tempSel = 0;
        perfIn = '0; rankRdThrEn = 0; rankWrThrEn = 0; fabricPeriod = 0;
        tick(2);
        rst_n = 1;
        tick(2);
        chk(actTempRd, ACT_TEMP, "act temp");
        chk(procHotNOe, 0, "pin oe");
        $display("test reset done");
        cfg.clkMonEn = 1; cfg.intOnAssert = 1; cfg.intOnDeassert = 1; coreHot = 2'h1;
        tick(1);
        chk(hotPinN, 0, "hot pin");
        chk(hotAssertIrq, 1, "hot irq");
        ondemandEn = 4'h5; ondemandDuty[0] = 3'h1; ondemandDuty[2] = 3'h4;
        tick(3); runs;
        chk(n0, AUTO_DUTY + 1, "auto duty");
        chk(n1, n0, "cores differ");
        coreHot = 0;
        tick(1);
        chk(hotDeassertIrq, 1, "cool irq");
        tick(3); runs;
        chk(n0, 5, "ondemand duty");
        ondemandEn = 0; cfg = '0; cfg.rvMonEn = 1; coreHot = 2'h2;
        tick(1);
        chk(coreRatio, 6'h0A, "ratio half");
        chk(coreVid, 6'h20, "vid early");
        tick(11);
        chk(coreVid, 6'h20 - VID_STEP, "vid step");
        coreHot = 0;
        tick(30);
        chk({coreRatio, coreVid}, {6'h14, 6'h20}, "restore");
        $display("test hot done");
        cfg = '0; cfg.clkMonEn = 1;
        extHot = 1;
        tick(3);
        chk(throttleActive, 0, "pin not bidir");
        cfg.hotBidir = 1; rankRdThrEn = 2'h1; rankWrThrEn = 2'h2; fabricPeriod = 8'h3;
        tick(3);
        chk(throttleActive, 1, "ext hot");
        chk(procHotNOe, 0, "pin echo");
        chk({rankRdThrottle, rankWrThrottle}, 4'h6, "ranks");
        runs;
        chk(n2, 2, "grants");
        extHot = 0;
        tick(4);
        chk(throttleActive, 0, "ext off");
        $display("test pin done");
        cfg = '0; cfg.alarmIrqEn = 1;
        for (int k = 0; k < 2; k++) begin
            cfg.alarmToSci = k[0]; thermalAlarmNIn = 0;
            tick(3);
            chk({smiReq, sciReq}, k ? 2'h1 : 2'h2, "alarm");
            thermalAlarmNIn = 1;
            tick(3);
        end
        cfg = '0; cfg.sensIrqEn = 1; cfg.sensThrottleEn = 1; threadThresh = {4{8'h50}};
        cfg.clkMonEn = 1;
        tempSel = 2'h2;
        for (int k = 0; k < 3; k++) begin
            cfg.sensIrqKind = 2'(k); threadTemp[2] = 8'h50;
            tick(1);
            chk({msiReq, smiReq, sciReq}, 3'h4 >> k, "sensor irq");
            chk(tempRdData, 8'h50, "temp read");
            chk(throttleActive, 1, "sensor throttle");
            threadTemp[2] = 8'h4F;
            tick(2);
        end
        perfIn = {8'h30, 8'h40, 8'h10};
        tick(1);
        chk(perfOut, {8'h30, 8'h40, 8'h10}, "perf");
        $display("test irq done");
        catTrip = 1;
        tick(1);
        chk({haltExec, tripPinN, coreClkRun}, 4'h8, "trip");
        catTrip = 0;
        tick(2);
        chk(sleepS5Req, 1, "soft off");
        $display("test trip done");
        summarize;
    end
endmodule : ttc_thermal_throttle_control_test
